// ---- core/flash_prot_pkg.sv ----
package flash_prot_pkg;
  // Array geometry
  localparam int unsigned ADDR_W     = 16;           // Byte address, 64 KB
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned WORD_AW    = 14;           // Word index width
  localparam int unsigned MEM_WORDS  = 16384;        // 64 KB of 32-bit words
  localparam int unsigned BLK_W      = 6;            // 64 erase blocks of 1 KB
  localparam int unsigned BLK_CNT_W  = 8;            // 256 words per block
  localparam int unsigned REGION_W   = 5;            // 32 protection regions of 2 KB
  localparam int unsigned REGIONS    = 32;
  localparam int unsigned MODE_W     = 2;
  // Address field positions
  localparam int unsigned WORD_LSB   = 2;
  localparam int unsigned BLK_LSB    = 10;
  localparam int unsigned REGION_LSB = 11;
  // Values
  localparam logic [DATA_W-1:0]    ERASED_WORD = 32'hffffffff;
  localparam logic [DATA_W-1:0]    ZERO_WORD   = 32'h00000000;
  localparam logic [BLK_CNT_W-1:0] BLK_LAST    = 8'hff;
  localparam logic [BLK_CNT_W-1:0] CNT_ZERO    = 8'h00;

  // Protection setting of one 2 KB region
  typedef enum logic [MODE_W-1:0] {MODE_OPEN, MODE_READ_ONLY, MODE_EXEC_ONLY} mode_t;
  // Requesting path
  typedef enum logic [1:0] {SRC_FETCH, SRC_DATA, SRC_DEBUG} src_t;
  // Requested operation
  typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_ERASE} op_t;
  // Controller states
  typedef enum logic {ST_IDLE, ST_ERASE} fsm_t;
endpackage : flash_prot_pkg

// ---- core/access_check_if.sv ----
`timescale 1ns/1ps
interface access_check_if;
  import flash_prot_pkg::*;
  op_t   op;     // Operation asked for
  src_t  src;    // Path that asks
  mode_t mode;   // Setting of the target region
  logic  allow;  // Access may proceed
  modport asker (output op, output src, output mode, input allow);
  modport judge (input op, input src, input mode, output allow);
endinterface : access_check_if

// ---- core/access_judge.sv ----
`timescale 1ns/1ps
module access_judge
  import flash_prot_pkg::*;
(
  // Decision channel
  access_check_if.judge chk
);
  // Grant or refuse one access by region setting
  always_comb begin
    case (chk.mode)
      // R5 read-only blocks writes
      MODE_READ_ONLY: chk.allow = (chk.op == OP_READ);
      // R6 R7 fetch-only reads
      MODE_EXEC_ONLY: chk.allow = (chk.op == OP_READ) && (chk.src == SRC_FETCH);
      MODE_OPEN:      chk.allow = 1'b1;
      default:        chk.allow = 1'b0;
    endcase
  end
endmodule : access_judge

// ---- core/flash_block_protection.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Flash array holds 64 KB
// R2 - Each 1 KB block erases alone
// R3 - Erased block reads all ones
// R4 - One setting per 2 KB region
// R5 - Read-only regions refuse erase and program
// R6 - Execute-only regions refuse erase and program
// R7 - Execute-only reads served to fetch only
// R8 - Permitted read completes in one cycle
// R9 - Refusal changes nothing, sets violation flag
module flash_block_protection
  import flash_prot_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Access request
  input  wire logic                req_valid,
  input  wire src_t                req_src,
  input  wire op_t                 req_op,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [DATA_W-1:0]   req_wdata,
  // Protection setting load
  input  wire logic                prot_wr,
  input  wire logic [REGION_W-1:0] prot_region,
  input  wire mode_t               prot_mode,
  // Answers
  output logic                     busy,
  output logic                     rd_valid,
  output logic [DATA_W-1:0]        rd_data,
  output logic                     refused,
  output logic                     op_done,
  // Violation flag
  output logic                     viol_flag,
  input  wire logic                viol_clr
);

  // Whole controller state
  typedef struct packed {
    fsm_t                     fsm;      // Idle or erasing
    logic [BLK_W-1:0]         eblk;     // Block being erased
    logic [BLK_CNT_W-1:0]     ecnt;     // Word within that block
    logic [REGIONS*MODE_W-1:0] prot;    // Region settings
    logic                     busy;     // Erase in progress
    logic                     rd_valid; // Read answer pulse
    logic [DATA_W-1:0]        rd_data;  // Read answer data
    logic                     refused;  // Refusal pulse
    logic                     op_done;  // Program or erase finished
    logic                     viol;     // Sticky violation
  } state_t;

  // Word index of a byte address
  function automatic logic [WORD_AW-1:0] word_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:WORD_LSB];
  endfunction : word_of

  // Protection region of a byte address
  function automatic logic [REGION_W-1:0] region_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:REGION_LSB];
  endfunction : region_of

  // Setting of one region out of the flat table
  function automatic mode_t mode_of(input logic [REGIONS*MODE_W-1:0] t,
                                    input logic [REGION_W-1:0] r);
    return mode_t'(t[r*MODE_W +: MODE_W]);
  endfunction : mode_of

  // R1 whole array storage
  logic [DATA_W-1:0]  mem [MEM_WORDS];

  state_t             st;        // Registered state
  state_t             next_st;   // Next state
  logic               accept;    // Request taken this cycle
  logic               mem_we;    // Array write strobe
  logic [WORD_AW-1:0] mem_wa;    // Array write index
  logic [DATA_W-1:0]  mem_wd;    // Array write data
  mode_t              cur_mode;  // Setting of the addressed region

  // Decision channel to the judge
  access_check_if chk ();

  access_judge u_judge (
    .chk (chk)
  );

  // R4 region of the request
  assign cur_mode = mode_of(st.prot, region_of(req_addr));
  assign chk.op   = req_op;
  assign chk.src  = req_src;
  assign chk.mode = cur_mode;
  // Requests are only looked at while no erase runs
  assign accept   = req_valid && !st.busy;

  // Next state and array write control
  always_comb begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    next_st.refused  = 1'b0;
    next_st.op_done  = 1'b0;
    mem_we           = 1'b0;
    mem_wa           = word_of(req_addr);
    mem_wd           = req_wdata;
    // R4 load one region setting
    if (prot_wr) begin
      next_st.prot[prot_region*MODE_W +: MODE_W] = prot_mode;
    end
    // Software clear of the sticky flag
    if (viol_clr) begin
      next_st.viol = 1'b0;
    end
    case (st.fsm)
      ST_IDLE: begin
        if (accept && !chk.allow) begin
          // R9 refuse, no data, flag set
          next_st.refused = 1'b1;
          next_st.rd_data = ZERO_WORD;
          next_st.viol    = 1'b1;
        end else if (accept) begin
          case (req_op)
            // R8 single cycle read
            OP_READ: begin
              next_st.rd_valid = 1'b1;
              next_st.rd_data  = mem[word_of(req_addr)];
            end
            // Programming only clears bits
            OP_PROGRAM: begin
              mem_we          = 1'b1;
              mem_wd          = mem[word_of(req_addr)] & req_wdata;
              next_st.op_done = 1'b1;
            end
            // R2 start one block erase
            OP_ERASE: begin
              next_st.fsm  = ST_ERASE;
              next_st.busy = 1'b1;
              next_st.eblk = req_addr[ADDR_W-1:BLK_LSB];
              next_st.ecnt = CNT_ZERO;
            end
            // Unused operation code: refuse and flag it
            default: begin
              next_st.refused = 1'b1;
              next_st.rd_data = ZERO_WORD;
              next_st.viol    = 1'b1;
            end
          endcase
        end
      end
      ST_ERASE: begin
        // R3 walk the block writing ones
        mem_we       = 1'b1;
        mem_wa       = {st.eblk, st.ecnt};
        mem_wd       = ERASED_WORD;
        next_st.ecnt = st.ecnt + 1'b1;
        if (st.ecnt == BLK_LAST) begin
          next_st.fsm     = ST_IDLE;
          next_st.busy    = 1'b0;
          next_st.op_done = 1'b1;
        end
      end
      default: begin
        next_st.fsm  = ST_IDLE;
        next_st.busy = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Constant reset image, every region open
      st.fsm      <= ST_IDLE;
      st.eblk     <= '0;
      st.ecnt     <= CNT_ZERO;
      st.prot     <= '0;
      st.busy     <= 1'b0;
      st.rd_valid <= 1'b0;
      st.rd_data  <= ZERO_WORD;
      st.refused  <= 1'b0;
      st.op_done  <= 1'b0;
      st.viol     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Array write port, contents survive reset
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Outputs straight from the state register
  assign busy      = st.busy;
  assign rd_valid  = st.rd_valid;
  assign rd_data   = st.rd_data;
  assign refused   = st.refused;
  assign op_done   = st.op_done;
  assign viol_flag = st.viol;

  // R8 read answer timing
  chk_read_latency: assert property ( // R8
    @(posedge core_clk) disable iff (rst)
    accept && req_op == OP_READ && (cur_mode == MODE_OPEN || cur_mode == MODE_READ_ONLY)
    |=> rd_valid && !refused)
    else $error("permitted read not answered next cycle");

  // R5 read-only write refusal
  chk_ronly_write: assert property ( // R5
    @(posedge core_clk) disable iff (rst)
    accept && req_op != OP_READ && cur_mode == MODE_READ_ONLY |=> refused && !busy)
    else $error("write to read-only region not refused");

  // R6 execute-only write refusal
  chk_xonly_write: assert property ( // R6
    @(posedge core_clk) disable iff (rst)
    accept && req_op != OP_READ && cur_mode == MODE_EXEC_ONLY |=> refused && !op_done)
    else $error("write to execute-only region not refused");

  // R7 execute-only data reads refused
  chk_xonly_data: assert property ( // R7
    @(posedge core_clk) disable iff (rst)
    accept && req_op == OP_READ && req_src != SRC_FETCH && cur_mode == MODE_EXEC_ONLY
    |=> refused && !rd_valid)
    else $error("non-fetch read of execute-only region served");

  // R9 refusal hides data and flags
  chk_refuse_flag: assert property ( // R9
    @(posedge core_clk) disable iff (rst)
    refused |-> viol_flag && rd_data == ZERO_WORD && !rd_valid)
    else $error("refusal without flag or with data");

  // R9 flag holds while no clear is applied
  chk_flag_sticky: assert property ( // R9
    @(posedge core_clk) disable iff (rst)
    viol_flag && !viol_clr |=> viol_flag)
    else $error("violation flag dropped without clear");

  // R2 erase lasts one block
  chk_erase_length: assert property ( // R2
    @(posedge core_clk) disable iff (rst)
    $rose(busy) |-> ##255 busy ##1 (!busy && op_done))
    else $error("erase did not cover exactly one block");

  // R3 erase writes only ones
  chk_erase_ones: assert property ( // R3
    @(posedge core_clk) disable iff (rst)
    st.fsm == ST_ERASE |-> mem_we && mem_wd == ERASED_WORD
    && mem_wa[WORD_AW-1 -: BLK_W] == st.eblk)
    else $error("erase wrote a non-one word or outside its block");

  // R4 loaded setting is held
  chk_prot_load: assert property ( // R4
    @(posedge core_clk) disable iff (rst)
    prot_wr |=> mode_of(st.prot, $past(prot_region)) == $past(prot_mode))
    else $error("region setting not stored");

endmodule : flash_block_protection

// ---- tb/req_port.sv ----
`timescale 1ns/1ps
module req_port
  import flash_prot_pkg::*;
(
  // Clock
  input  wire logic              core_clk,
  // Request group
  output logic                   req_valid,
  output src_t                   req_src,
  output op_t                    req_op,
  output logic [ADDR_W-1:0]      req_addr,
  output logic [DATA_W-1:0]      req_wdata,
  // Answers
  input  wire logic              busy,
  input  wire logic              rd_valid,
  input  wire logic              refused,
  input  wire logic              op_done
);
  // Idle request lines
  initial begin
    req_valid = 1'b0;
    req_src   = SRC_FETCH;
    req_op    = OP_READ;
    req_addr  = 16'h0000;
    req_wdata = 32'h00000000;
  end

  // One request held to its taking edge, then wait for the answer
  task automatic issue(input src_t s, input op_t o, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output int lat, output logic b1);
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req_src   = s;
    req_op    = o;
    req_addr  = a;
    req_wdata = d;
    @(posedge core_clk);
    #1;
    // Released address and data lines show a changed pattern, not the old value
    req_valid = 1'b0;
    req_addr  = ~a;
    req_wdata = ~d;
    b1        = busy;
    lat       = 1;
    while (!(rd_valid || refused || op_done) && lat < 400) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
  endtask : issue
endmodule : req_port

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import flash_prot_pkg::*;
  logic core_clk, rst, req_valid, prot_wr, viol_clr, busy, rd_valid, refused, op_done;
  logic viol_flag, b1;
  src_t req_src;
  op_t req_op;
  mode_t prot_mode;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rd_data;
  logic [REGION_W-1:0] prot_region;
  int errors, n_compared, lat;

  flash_block_protection uut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req_src(req_src), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .prot_wr(prot_wr), .prot_region(prot_region), .prot_mode(prot_mode), .busy(busy),
    .rd_valid(rd_valid), .rd_data(rd_data), .refused(refused), .op_done(op_done),
    .viol_flag(viol_flag), .viol_clr(viol_clr));
  req_port far (.core_clk(core_clk), .req_valid(req_valid), .req_src(req_src),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
    .rd_valid(rd_valid), .refused(refused), .op_done(op_done));

  // Compare and count
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk
  // Served read in one cycle with given word
  task automatic rd(src_t s, logic [15:0] a, logic [31:0] exp);
    far.issue(s, OP_READ, a, 32'h0, lat, b1);
    chk("read latency", 1, lat);
    chk("rd_valid", 1, {31'h0, rd_valid});
    chk("rd_data", exp, rd_data);
  endtask : rd
  // Refused request: no data, flag set
  task automatic deny(src_t s, op_t o, logic [15:0] a);
    far.issue(s, o, a, 32'h0, lat, b1);
    chk("refused", 1, {31'h0, refused});
    chk("refuse rd_data", 0, rd_data);
    chk("viol_flag", 1, {31'h0, viol_flag});
  endtask : deny
  // Erase a block, expect busy then done after 257 cycles
  task automatic erase(logic [15:0] a);
    far.issue(SRC_DATA, OP_ERASE, a, 32'h0, lat, b1);
    chk("erase busy", 1, {31'h0, b1});
    chk("erase latency", 257, lat);
  endtask : erase
  // Load one region setting
  task automatic set_mode(logic [4:0] r, mode_t m);
    @(posedge core_clk);
    #1;
    prot_wr     = 1'b1;
    prot_region = r;
    prot_mode   = m;
    @(posedge core_clk);
    #1;
    prot_wr     = 1'b0;
  endtask : set_mode

  // Open regions: erase, program, block independence
  task automatic test_open;
    erase(16'h0400);
    far.issue(SRC_DATA, OP_PROGRAM, 16'h0400, 32'h12345678, lat, b1);
    chk("program done", 1, {31'h0, op_done});
    erase(16'h0000);
    rd(SRC_DATA, 16'h0400, 32'h12345678);
    rd(SRC_DATA, 16'h03fc, 32'hffffffff);
    rd(SRC_DEBUG, 16'h0000, 32'hffffffff);
    far.issue(SRC_DATA, OP_PROGRAM, 16'h0004, 32'hf0f0ff00, lat, b1);
    far.issue(SRC_DATA, OP_PROGRAM, 16'h0004, 32'h3c3c0fff, lat, b1);
    rd(SRC_DATA, 16'h0004, 32'h30300f00);
    erase(16'hfc00);
    rd(SRC_DATA, 16'hfffc, 32'hffffffff);
    $display("test_open done");
  endtask : test_open
  // Read-only region refuses changes, flag clears
  task automatic test_read_only;
    set_mode(5'h00, MODE_READ_ONLY);
    deny(SRC_DATA, OP_PROGRAM, 16'h0004);
    deny(SRC_DEBUG, OP_ERASE, 16'h0000);
    rd(SRC_DEBUG, 16'h0004, 32'h30300f00);
    viol_clr = 1'b1;
    @(posedge core_clk);
    #1;
    viol_clr = 1'b0;
    chk("flag cleared", 0, {31'h0, viol_flag});
    $display("test_read_only done");
  endtask : test_read_only
  // Execute-only region serves fetch only
  task automatic test_exec_only;
    set_mode(5'h00, MODE_EXEC_ONLY);
    deny(SRC_FETCH, OP_PROGRAM, 16'h0004);
    deny(SRC_FETCH, OP_ERASE, 16'h0400);
    rd(SRC_FETCH, 16'h0004, 32'h30300f00);
    deny(SRC_DATA, OP_READ, 16'h0004);
    deny(SRC_DEBUG, OP_READ, 16'h0400);
    rd(SRC_DATA, 16'hfffc, 32'hffffffff);
    set_mode(5'h00, MODE_OPEN);
    rd(SRC_DATA, 16'h0400, 32'h12345678);
    rd(SRC_DEBUG, 16'h0004, 32'h30300f00);
    // Clear held across a refusal: the set wins
    viol_clr = 1'b1;
    deny(SRC_DATA, op_t'(2'h3), 16'h0800);
    viol_clr = 1'b0;
    // Unused setting refuses every access
    set_mode(5'h01, mode_t'(2'h3));
    deny(SRC_FETCH, OP_READ, 16'h0800);
    $display("test_exec_only done");
  endtask : test_exec_only
  // Reset in mid-run: settings open, flag low, array kept
  task automatic test_reset;
    set_mode(5'h00, MODE_EXEC_ONLY);
    deny(SRC_DEBUG, OP_READ, 16'h0004);
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk("reset viol_flag", 0, {31'h0, viol_flag});
    chk("reset rd_data", 0, rd_data);
    rd(SRC_DEBUG, 16'h0004, 32'h30300f00);
    $display("test_reset done");
  endtask : test_reset

  // Print counts and verdict
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Watchdog
  initial begin
    #(40 * 5000);
    errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    prot_wr = 1'b0;
    prot_region = 5'h00;
    prot_mode = MODE_OPEN;
    viol_clr = 1'b0;
    errors = 0;
    n_compared = 0;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    test_open();
    test_read_only();
    test_exec_only();
    test_reset();
    end_of_test();
  end
endmodule : testbench
